// ===== shift_register_pkg.sv
// Constants shared by the four-stage bidirectional shift register and its register interface.
// What this block does
// - While clear is low, all four stages are forced low; other inputs are ignored.
// - With clear high, contents change only on an enabled rising edge of the shift clock, or on a software step or clear.
// - Both mode bits high: a rising edge loads the four parallel inputs, in order.
// - Upper low, lower high: shift toward the last stage, first takes right serial.
// - Upper high, lower low: shift toward the first stage, last takes left serial.
// - Both mode bits low: all stages keep their prior values.
package shift_register_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] EDGE_COUNT_OFFSET = 12'h008;

    localparam int CTRL_SW_CLEAR_BIT = 0;
    localparam int CTRL_SW_STEP_BIT = 1;
    localparam int CTRL_PIN_CLOCK_EN_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

    localparam int STATUS_STAGES_LSB = 0;
    localparam int STATUS_MODE_LSB = 4;
    localparam int STATUS_CLEAR_PIN_BIT = 6;
    localparam int STATUS_LAST_OP_LSB = 8;

    localparam int EDGE_COUNT_WIDTH = 16;
    localparam logic [15:0] EDGE_COUNT_RESET = 16'h0000;
    localparam logic [3:0] STAGES_RESET = 4'h0;

    // ************************************************************
    // Mode select encodings, written as {upper, lower}
    // ************************************************************
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_SHIFT_RIGHT = 2'h1;
    localparam logic [1:0] MODE_SHIFT_LEFT = 2'h2;
    localparam logic [1:0] MODE_LOAD = 2'h3;

    // Last operation performed, one-hot.
    typedef enum logic [4:0] {
        OP_CLEAR = 5'h01,
        OP_HOLD = 5'h02,
        OP_RIGHT = 5'h04,
        OP_LEFT = 5'h08,
        OP_LOAD = 5'h10
    } last_op_e;

endpackage

// ===== shift_stages.sv
// Storage stages of the universal shift register with per-stage next-value selection.
`timescale 1ns/1ns
module shift_stages #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic step,
    input wire logic [1:0] mode,
    input wire logic right_in,
    input wire logic left_in,
    input wire logic [WIDTH-1:0] par_in,
    output logic [WIDTH-1:0] stages_reg
);

    generate
        if (WIDTH < 2) begin : g_bad_width
            $error("shift_stages needs at least two stages");
        end
    endgenerate

    logic [WIDTH-1:0] stages_next;

    // ************************************************************
    // Next value per stage; index 0 is the first stage
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_stage
            logic from_prev;
            logic from_succ;
            if (i == 0) begin : g_first
                assign from_prev = right_in;
            end else begin : g_mid_prev
                assign from_prev = stages_reg[i-1];
            end
            if (i == WIDTH - 1) begin : g_last
                assign from_succ = left_in;
            end else begin : g_mid_succ
                assign from_succ = stages_reg[i+1];
            end
            always_comb begin
                stages_next[i] = stages_reg[i];
                if (clear) begin
                    stages_next[i] = 1'b0;
                end else if (step) begin
                    case (mode)
                        shift_register_pkg::MODE_LOAD: stages_next[i] = par_in[i];
                        shift_register_pkg::MODE_SHIFT_RIGHT: stages_next[i] = from_prev;
                        shift_register_pkg::MODE_SHIFT_LEFT: stages_next[i] = from_succ;
                        default: stages_next[i] = stages_reg[i];
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stages_reg <= WIDTH'(0);
        end else begin
            stages_reg <= stages_next;
        end
    end

endmodule

// ===== bidirectional_shift_register_4bit.sv
// Four-stage bidirectional shift register with pin control and an APB register interface.
`timescale 1ns/1ns
module bidirectional_shift_register_4bit #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CLEAR_N,
    input wire logic SHIFT_CLOCK,
    input wire logic MODE_SELECT_UPPER,
    input wire logic MODE_SELECT_LOWER,
    input wire logic RIGHT_SHIFT_SERIAL_IN,
    input wire logic LEFT_SHIFT_SERIAL_IN,
    input wire logic PARALLEL_IN_ONE,
    input wire logic PARALLEL_IN_TWO,
    input wire logic PARALLEL_IN_THREE,
    input wire logic PARALLEL_IN_FOUR,
    output logic STAGE_ONE_OUT,
    output logic STAGE_TWO_OUT,
    output logic STAGE_THREE_OUT,
    output logic STAGE_FOUR_OUT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_WIDTH-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    generate
        if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_bad_addr
            $error("ADDR_WIDTH must lie between 4 and 32");
        end
    endgenerate

    // ************************************************************
    // Pin sampling and clock edge detection
    // ************************************************************
    logic [1:0] mode;
    logic [3:0] par_in;
    logic shift_clock_prev_reg;
    logic pin_rise;
    logic clear;
    logic step;

    assign mode = {MODE_SELECT_UPPER, MODE_SELECT_LOWER};
    assign par_in = {PARALLEL_IN_FOUR, PARALLEL_IN_THREE, PARALLEL_IN_TWO, PARALLEL_IN_ONE};

    // The shift clock pin is an ordinary synchronous input; only its low-to-high change acts.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            shift_clock_prev_reg <= 1'b0;
        end else begin
            shift_clock_prev_reg <= SHIFT_CLOCK;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    logic apb_write;
    logic apb_setup;
    logic addr_ctrl;
    logic addr_status;
    logic addr_count;
    logic addr_hit;
    logic [31:0] ctrl_reg;
    logic sw_clear_reg;
    logic sw_step_reg;
    logic pin_clock_en;

    assign apb_setup = PSEL && !PENABLE;
    assign apb_write = PSEL && PENABLE && PWRITE && PSTRB[0];

    always_comb begin
        addr_ctrl = 1'b0;
        addr_status = 1'b0;
        addr_count = 1'b0;
        if (32'(PADDR) == 32'(shift_register_pkg::CTRL_OFFSET)) begin
            addr_ctrl = 1'b1;
        end else if (32'(PADDR) == 32'(shift_register_pkg::STATUS_OFFSET)) begin
            addr_status = 1'b1;
        end else if (32'(PADDR) == 32'(shift_register_pkg::EDGE_COUNT_OFFSET)) begin
            addr_count = 1'b1;
        end
    end

    assign addr_hit = addr_ctrl || addr_status || addr_count;

    // The pin clock can be gated off so that software alone steps the register.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_reg <= shift_register_pkg::CTRL_RESET;
        end else if (apb_write && addr_ctrl) begin
            ctrl_reg <= {29'h0000_0000, PWDATA[shift_register_pkg::CTRL_PIN_CLOCK_EN_BIT], 2'h0};
        end
    end

    // Software clear and step are one-cycle pulses; writing a one does not stay in the register.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sw_clear_reg <= 1'b0;
        end else begin
            sw_clear_reg <= apb_write && addr_ctrl && PWDATA[shift_register_pkg::CTRL_SW_CLEAR_BIT];
        end
    end

    // A step written together with a clear is lost, because clear wins in the stages.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sw_step_reg <= 1'b0;
        end else begin
            sw_step_reg <= apb_write && addr_ctrl && PWDATA[shift_register_pkg::CTRL_SW_STEP_BIT];
        end
    end

    assign pin_clock_en = ctrl_reg[shift_register_pkg::CTRL_PIN_CLOCK_EN_BIT];
    assign pin_rise = pin_clock_en && SHIFT_CLOCK && !shift_clock_prev_reg;
    assign clear = !CLEAR_N || sw_clear_reg;
    assign step = pin_rise || sw_step_reg;

    // ************************************************************
    // Storage stages
    // ************************************************************
    logic [3:0] stages_reg;

    // Mode and data are taken only in the cycle of the edge, so they must be steady then.
    shift_stages #(
        .WIDTH(4)
    ) u_stages (
        .clk(CLK),
        .rst_n(RST_N),
        .clear(clear),
        .step(step),
        .mode(mode),
        .right_in(RIGHT_SHIFT_SERIAL_IN),
        .left_in(LEFT_SHIFT_SERIAL_IN),
        .par_in(par_in),
        .stages_reg(stages_reg)
    );

    // Outputs are the stage flip-flops themselves, with no further register between.
    assign STAGE_ONE_OUT = stages_reg[0];
    assign STAGE_TWO_OUT = stages_reg[1];
    assign STAGE_THREE_OUT = stages_reg[2];
    assign STAGE_FOUR_OUT = stages_reg[3];

    // ************************************************************
    // Last operation and edge counter
    // ************************************************************
    shift_register_pkg::last_op_e last_op_reg;
    shift_register_pkg::last_op_e last_op_next;
    logic [shift_register_pkg::EDGE_COUNT_WIDTH-1:0] edge_count_reg;
    logic [shift_register_pkg::EDGE_COUNT_WIDTH-1:0] edge_count_next;

    always_comb begin
        last_op_next = last_op_reg;
        if (clear) begin
            last_op_next = shift_register_pkg::OP_CLEAR;
        end else if (step) begin
            case (mode)
                shift_register_pkg::MODE_LOAD: last_op_next = shift_register_pkg::OP_LOAD;
                shift_register_pkg::MODE_SHIFT_RIGHT: last_op_next = shift_register_pkg::OP_RIGHT;
                shift_register_pkg::MODE_SHIFT_LEFT: last_op_next = shift_register_pkg::OP_LEFT;
                default: last_op_next = shift_register_pkg::OP_HOLD;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            last_op_reg <= shift_register_pkg::OP_CLEAR;
        end else begin
            last_op_reg <= last_op_next;
        end
    end

    // A write clears the counter, but an edge in the same cycle still counts.
    always_comb begin
        edge_count_next = edge_count_reg;
        if (apb_write && addr_count) begin
            edge_count_next = shift_register_pkg::EDGE_COUNT_RESET;
        end
        if (step && !clear) begin
            edge_count_next = edge_count_next + 16'h0001;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            edge_count_reg <= shift_register_pkg::EDGE_COUNT_RESET;
        end else begin
            edge_count_reg <= edge_count_next;
        end
    end

    // ************************************************************
    // APB read path
    // ************************************************************
    logic [31:0] rdata_next;
    logic [31:0] status_word;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[shift_register_pkg::STATUS_STAGES_LSB +: 4] = stages_reg;
        status_word[shift_register_pkg::STATUS_MODE_LSB +: 2] = mode;
        status_word[shift_register_pkg::STATUS_CLEAR_PIN_BIT] = CLEAR_N;
        status_word[shift_register_pkg::STATUS_LAST_OP_LSB +: 5] = last_op_reg;
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (addr_ctrl) begin
            rdata_next = ctrl_reg;
        end else if (addr_status) begin
            rdata_next = status_word;
        end else if (addr_count) begin
            rdata_next = {16'h0000, edge_count_reg};
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop in the access cycle.
    // The status word therefore shows the stages as they stood at the setup edge.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prdata_reg <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_reg <= PWRITE ? 32'h0000_0000 : rdata_next;
        end
    end

    // The error flag is decided at setup as well, so the access cycle needs no decoding.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            pslverr_reg <= !addr_hit;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && pslverr_reg;

endmodule

// ===== pin_driver_model.sv
// Model of the surrounding logic that drives the shift register's control and data pins.
`timescale 1ns/1ns
module pin_driver_model (
    input wire logic clk,
    output logic clear_n,
    output logic shift_clock,
    output logic [1:0] mode,
    output logic right_in,
    output logic left_in,
    output logic [3:0] par
);
    initial begin
        clear_n = 1'b1;
        shift_clock = 1'b0;
        mode = 2'h0;
        right_in = 1'b0;
        left_in = 1'b0;
        par = 4'h0;
    end
    // Mode and data settle a full cycle before the clock rises and stay until the next request.
    task pulse(input logic [1:0] m, input logic r, input logic l, input logic [3:0] p);
        mode <= m;
        right_in <= r;
        left_in <= l;
        par <= p;
        @(posedge clk);
        shift_clock <= 1'b1;
        @(posedge clk);
        shift_clock <= 1'b0;
        @(posedge clk);
    endtask
    task clear_pulse(input logic [3:0] p);
        clear_n <= 1'b0;
        pulse(2'h3, 1'b1, 1'b1, p);
        clear_n <= 1'b1;
        @(posedge clk);
    endtask
endmodule

// ===== bidirectional_shift_register_4bit_sva.sv
// Concurrent checks of the stage outputs against the pin controls.
`timescale 1ns/1ns
module shift_register_checker #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CLEAR_N,
    input wire logic SHIFT_CLOCK,
    input wire logic MODE_SELECT_UPPER,
    input wire logic MODE_SELECT_LOWER,
    input wire logic RIGHT_SHIFT_SERIAL_IN,
    input wire logic LEFT_SHIFT_SERIAL_IN,
    input wire logic PARALLEL_IN_ONE,
    input wire logic PARALLEL_IN_TWO,
    input wire logic PARALLEL_IN_THREE,
    input wire logic PARALLEL_IN_FOUR,
    input wire logic STAGE_ONE_OUT,
    input wire logic STAGE_TWO_OUT,
    input wire logic STAGE_THREE_OUT,
    input wire logic STAGE_FOUR_OUT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_WIDTH-1:0] PADDR,
    input wire logic [31:0] PWDATA
);
    logic sc_q;
    logic en_q;
    logic wr_ctrl;
    logic sw_clr_q;
    logic sw_step_q;
    logic clr;
    logic act;
    logic [1:0] m;
    logic [3:0] q;
    logic [3:0] p;
    assign m = {MODE_SELECT_UPPER, MODE_SELECT_LOWER};
    assign q = {STAGE_FOUR_OUT, STAGE_THREE_OUT, STAGE_TWO_OUT, STAGE_ONE_OUT};
    assign p = {PARALLEL_IN_FOUR, PARALLEL_IN_THREE, PARALLEL_IN_TWO, PARALLEL_IN_ONE};
    assign wr_ctrl = PSEL && PENABLE && PWRITE && (32'(PADDR) == 32'(shift_register_pkg::CTRL_OFFSET));
    assign clr = !CLEAR_N || sw_clr_q;
    assign act = !clr && ((en_q && SHIFT_CLOCK && !sc_q) || sw_step_q);
    always_ff @(posedge CLK) begin
        sc_q <= SHIFT_CLOCK;
    end
    // The pin clock enable lives in the control word, so it is shadowed here.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            en_q <= 1'b1;
        end else if (wr_ctrl) begin
            en_q <= PWDATA[shift_register_pkg::CTRL_PIN_CLOCK_EN_BIT];
        end
    end
    // Software clear and step act one cycle after the control write, like a pin clear or edge.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sw_clr_q <= 1'b0;
            sw_step_q <= 1'b0;
        end else begin
            sw_clr_q <= wr_ctrl && PWDATA[shift_register_pkg::CTRL_SW_CLEAR_BIT];
            sw_step_q <= wr_ctrl && PWDATA[shift_register_pkg::CTRL_SW_STEP_BIT];
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    sequence s_edge(logic [1:0] mm);
        act && m == mm;
    endsequence
    sequence s_cleared;
        clr ##1 (!clr && !act);
    endsequence
    property p_clear;
        clr |=> q == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("stages not cleared");
    property p_after_clear;
        s_cleared |=> q == 4'h0;
    endproperty
    a_after_clear: assert property (p_after_clear) else $error("stages moved after clear");
    property p_idle;
        !clr && !act |=> $stable(q);
    endproperty
    a_idle: assert property (p_idle) else $error("stages moved without clock edge");
    property p_load;
        s_edge(shift_register_pkg::MODE_LOAD) |=> q == $past(p);
    endproperty
    a_load: assert property (p_load) else $error("parallel load wrong");
    property p_right;
        s_edge(shift_register_pkg::MODE_SHIFT_RIGHT) |=> q == {$past(q[2:0]), $past(RIGHT_SHIFT_SERIAL_IN)};
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");
    property p_left;
        s_edge(shift_register_pkg::MODE_SHIFT_LEFT) |=> q == {$past(LEFT_SHIFT_SERIAL_IN), $past(q[3:1])};
    endproperty
    a_left: assert property (p_left) else $error("left shift wrong");
    property p_hold;
        s_edge(shift_register_pkg::MODE_HOLD) |=> $stable(q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold mode changed stages");
endmodule
bind bidirectional_shift_register_4bit shift_register_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_shift_register_checker (
    .CLK(CLK), .RST_N(RST_N), .CLEAR_N(CLEAR_N), .SHIFT_CLOCK(SHIFT_CLOCK),
    .MODE_SELECT_UPPER(MODE_SELECT_UPPER), .MODE_SELECT_LOWER(MODE_SELECT_LOWER),
    .RIGHT_SHIFT_SERIAL_IN(RIGHT_SHIFT_SERIAL_IN), .LEFT_SHIFT_SERIAL_IN(LEFT_SHIFT_SERIAL_IN),
    .PARALLEL_IN_ONE(PARALLEL_IN_ONE), .PARALLEL_IN_TWO(PARALLEL_IN_TWO),
    .PARALLEL_IN_THREE(PARALLEL_IN_THREE), .PARALLEL_IN_FOUR(PARALLEL_IN_FOUR),
    .STAGE_ONE_OUT(STAGE_ONE_OUT), .STAGE_TWO_OUT(STAGE_TWO_OUT),
    .STAGE_THREE_OUT(STAGE_THREE_OUT), .STAGE_FOUR_OUT(STAGE_FOUR_OUT),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA)
);

// ===== test_bidirectional_shift_register_4bit.sv
// Self-checking bench of the four-stage bidirectional shift register.
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_bidirectional_shift_register_4bit;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic clear_n;
    logic shift_clock;
    logic [1:0] mode;
    logic right_in;
    logic left_in;
    logic [3:0] par;
    wire [3:0] q;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    logic [31:0] seen;
    logic [31:0] exp_q[$];
    logic [1:0] src_q[$];
    string nm_q[$];
    int failures = 0;
    int total_checks = 0;
    always #2 clk = ~clk;
    pin_driver_model u_pin_driver_model (.clk(clk), .clear_n(clear_n), .shift_clock(shift_clock), .mode(mode),
        .right_in(right_in), .left_in(left_in), .par(par));
    bidirectional_shift_register_4bit u_bidirectional_shift_register_4bit (
        .CLK(clk), .RST_N(rst_n), .CLEAR_N(clear_n), .SHIFT_CLOCK(shift_clock),
        .MODE_SELECT_UPPER(mode[1]), .MODE_SELECT_LOWER(mode[0]),
        .RIGHT_SHIFT_SERIAL_IN(right_in), .LEFT_SHIFT_SERIAL_IN(left_in),
        .PARALLEL_IN_ONE(par[0]), .PARALLEL_IN_TWO(par[1]), .PARALLEL_IN_THREE(par[2]), .PARALLEL_IN_FOUR(par[3]),
        .STAGE_ONE_OUT(q[0]), .STAGE_TWO_OUT(q[1]), .STAGE_THREE_OUT(q[2]), .STAGE_FOUR_OUT(q[3]),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
    );
    // ****************************************
    // Expected results and their comparison
    // ****************************************
    task note(input string nm, input logic [1:0] s, input logic [31:0] e);
        nm_q.push_back(nm);
        src_q.push_back(s);
        exp_q.push_back(e);
    endtask
    always @(negedge clk) begin
        while (exp_q.size() > 0) begin
            seen = (src_q[0] == 2'h0) ? {28'h0, q} : (src_q[0] == 2'h1) ? rd : {31'h0, err};
            `CHECK(nm_q[0], exp_q[0], seen)
            void'(exp_q.pop_front());
            void'(src_q.pop_front());
            void'(nm_q.pop_front());
        end
    end
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        int seed;
        logic [3:0] e;
        logic [1:0] m;
        logic r;
        logic l;
        logic [3:0] p;
        seed = 77883;
        e = 4'h0;
        m = 2'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, shift_register_pkg::CTRL_OFFSET, 32'h0);
        note("ctrl", 2'h1, shift_register_pkg::CTRL_RESET);
        apb(1'b0, shift_register_pkg::STATUS_OFFSET, 32'h0);
        note("status", 2'h1, 32'h0000_0140);
        $display("reset values done");
        for (int i = 0; i < 24; i++) begin
            m = 2'(i) ^ 2'(i >> 2);
            {r, l, p} = 6'($random(seed));
            u_pin_driver_model.pulse(m, r, l, p);
            case (m)
                shift_register_pkg::MODE_LOAD: e = p;
                shift_register_pkg::MODE_SHIFT_RIGHT: e = {e[2:0], r};
                shift_register_pkg::MODE_SHIFT_LEFT: e = {l, e[3:1]};
                default: e = e;
            endcase
            note("stages", 2'h0, {28'h0, e});
        end
        apb(1'b0, shift_register_pkg::STATUS_OFFSET, 32'h0);
        note("status", 2'h1, {19'h0, 5'h02 << m, 2'h1, m, e});
        $display("mode test done");
        u_pin_driver_model.clear_pulse(4'hf);
        note("cleared", 2'h0, 32'h0);
        $display("clear test done");
        apb(1'b1, shift_register_pkg::EDGE_COUNT_OFFSET, 32'h0);
        apb(1'b1, shift_register_pkg::CTRL_OFFSET, 32'h0);
        u_pin_driver_model.pulse(shift_register_pkg::MODE_LOAD, 1'b0, 1'b0, 4'ha);
        note("disabled", 2'h0, 32'h0);
        apb(1'b1, shift_register_pkg::CTRL_OFFSET, 32'h4);
        u_pin_driver_model.pulse(shift_register_pkg::MODE_SHIFT_RIGHT, 1'b1, 1'b0, 4'h0);
        note("right", 2'h0, 32'h1);
        apb(1'b0, shift_register_pkg::EDGE_COUNT_OFFSET, 32'h0);
        note("count", 2'h1, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        note("unmapped", 2'h1, 32'h0);
        note("unmapped err", 2'h2, 32'h1);
        $display("register test done");
        apb(1'b1, shift_register_pkg::CTRL_OFFSET, 32'h6);
        note("sw step", 2'h0, 32'h3);
        apb(1'b1, shift_register_pkg::CTRL_OFFSET, 32'h5);
        note("sw clear", 2'h0, 32'h0);
        apb(1'b0, shift_register_pkg::CTRL_OFFSET, 32'h0);
        note("ctrl pulses", 2'h1, 32'h4);
        $display("software test done");
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule
